/* hdl/subtract_and_sleep_exec_unit.sv */
// Subtract and sleep execution unit with an Avalon-MM register slave
//
// Behaviour
// - literal minus working register, two's complement
// - literal result to W, C DC Z updated
// - file minus W, borrow clears C DC
// - destination bit picks W or file
// - file minus W minus inverted carry
// - borrow result destination picks W or file
// - sleep clears watchdog, prescaler; TO set, PD cleared
// - sleep halts core and stops oscillator
// - start-up timer counts 1024 cycles before stable
`timescale 1ns/1ps
module subtract_and_sleep_exec_unit
    import sub_exec_pkg::*;
#(
    parameter int FILE_DEPTH = 128
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic osc_run,
    output logic sleeping,
    output logic osc_stable
);
    generate
        if (FILE_DEPTH < 1 || FILE_DEPTH > 128) begin : g_bad_depth
            $error("FILE_DEPTH must lie in 1..128");
        end
    endgenerate

    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0] w_q, w_d;
    alu_flags_s flags_q, flags_d;
    pwr_flags_s pwr_q, pwr_d;
    pwr_state_e st_q, st_d;
    logic [OST_W-1:0] ost_q, ost_d;
    logic [7:0] pre_q, pre_d;
    logic [7:0] wdt_q, wdt_d;
    logic [6:0] faddr_q, faddr_d;
    logic [7:0] file_q [FILE_DEPTH];
    logic [7:0] file_d [FILE_DEPTH];
    logic run_q, run_d;
    logic sleep_q, sleep_d;
    logic stable_q, stable_d;
    logic [OST_W-1:0] hc_q, hc_d;

    // Out-of-range file addresses read as zero
    function automatic logic [7:0] file_rd(input logic [6:0] a);
        file_rd = (int'(a) < FILE_DEPTH) ? file_q[a] : 8'h00;
    endfunction

    // Returns {carry, half carry, difference}; carry set means no borrow
    function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b,
                                        input logic bin);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} - {1'b0, b} - {8'h00, bin};
        low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
        sub8 = {~full[8], ~low[4], full[7:0]};
    endfunction

    logic acc;
    logic cmd_acc;
    op_e cmd_op;
    logic cmd_dest;
    logic [6:0] cmd_fa;
    logic [7:0] cmd_lit;
    logic [7:0] cmd_fval;
    logic [7:0] op_a;
    logic op_bin;
    logic [9:0] sub_res;
    logic wake_acc;

    assign acc = (read | write) & ~wait_q;
    assign cmd_acc = write & ~wait_q & (address == ADDR_CMD) & (st_q == ST_RUN);
    assign cmd_op = op_e'(writedata[CMD_OP_LSB +: 2]);
    assign cmd_dest = writedata[CMD_DEST_BIT];
    assign cmd_fa = writedata[CMD_FA_LSB +: 7];
    assign cmd_lit = writedata[CMD_LIT_LSB +: 8];
    assign cmd_fval = file_rd(cmd_fa);
    assign op_a = (cmd_op == OP_LIT) ? cmd_lit : cmd_fval;
    assign op_bin = (cmd_op == OP_BORROW) ? ~flags_q.carry : 1'b0;
    assign sub_res = sub8(op_a, w_q, op_bin);
    assign wake_acc = write & ~wait_q & (address == ADDR_WAKE) & (st_q == ST_SLEEP)
                      & writedata[0];

    always_comb begin
        wait_d = 1'b1;
        rdata_d = rdata_q;
        w_d = w_q;
        flags_d = flags_q;
        pwr_d = pwr_q;
        st_d = st_q;
        ost_d = ost_q;
        pre_d = pre_q;
        wdt_d = wdt_q;
        faddr_d = faddr_q;
        file_d = file_q;
        // Answer every request after exactly one wait cycle
        if ((read | write) && wait_q) begin
            wait_d = 1'b0;
            rdata_d = 32'h0000_0000;
            case (address)
                ADDR_WREG: rdata_d[7:0] = w_q;
                ADDR_STATUS: begin
                    rdata_d[ST_C_BIT] = flags_q.carry;
                    rdata_d[ST_DC_BIT] = flags_q.half_carry_flag;
                    rdata_d[ST_Z_BIT] = flags_q.zero;
                    rdata_d[ST_PD_BIT] = pwr_q.power_down_flag;
                    rdata_d[ST_TO_BIT] = pwr_q.timeout_flag;
                    rdata_d[ST_SLEEP_BIT] = sleep_q;
                    rdata_d[ST_STABLE_BIT] = stable_q;
                end
                ADDR_FADDR: rdata_d[6:0] = faddr_q;
                ADDR_FDATA: rdata_d[7:0] = file_rd(faddr_q);
                ADDR_WDT: rdata_d[15:0] = {pre_q, wdt_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
        case (st_q)
            ST_OST: begin
                ost_d = ost_q + 1'b1;
                if (ost_q == OST_W'(OST_CYCLES - 1)) begin
                    st_d = ST_RUN;
                end
            end
            ST_RUN: begin
                pre_d = pre_q + 1'b1;
                if (pre_q == 8'hFF) begin
                    wdt_d = wdt_q + 1'b1;
                end
            end
            ST_SLEEP: begin
                if (wake_acc) begin
                    st_d = ST_OST;
                    ost_d = '0;
                end
            end
            default: st_d = ST_OST;
        endcase
        if (write && acc) begin
            case (address)
                ADDR_WREG: w_d = writedata[7:0];
                ADDR_STATUS: begin
                    flags_d.carry = writedata[ST_C_BIT];
                    flags_d.half_carry_flag = writedata[ST_DC_BIT];
                    flags_d.zero = writedata[ST_Z_BIT];
                end
                ADDR_FADDR: faddr_d = writedata[6:0];
                ADDR_FDATA: begin
                    if (int'(faddr_q) < FILE_DEPTH) begin
                        file_d[faddr_q] = writedata[7:0];
                    end
                end
                default: begin
                end
            endcase
        end
        if (cmd_acc) begin
            if (cmd_op == OP_SLEEP) begin
                wdt_d = WDT_CLEARED;
                pre_d = PRE_CLEARED;
                pwr_d.timeout_flag = 1'b1;
                pwr_d.power_down_flag = 1'b0;
                st_d = ST_SLEEP;
            end else begin
                flags_d.carry = sub_res[9];
                flags_d.half_carry_flag = sub_res[8];
                flags_d.zero = (sub_res[7:0] == 8'h00);
                if (cmd_op == OP_LIT || !cmd_dest) begin
                    w_d = sub_res[7:0];
                end else if (int'(cmd_fa) < FILE_DEPTH) begin
                    file_d[cmd_fa] = sub_res[7:0];
                end
            end
        end
        run_d = (st_d != ST_SLEEP);
        sleep_d = (st_d == ST_SLEEP);
        stable_d = (st_d == ST_RUN);
        hc_d = (st_q == ST_OST) ? hc_q + 1'b1 : '0;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            w_q <= W_RESET;
            flags_q <= FLAGS_RESET;
            pwr_q <= PWR_RESET;
            st_q <= ST_OST;
            ost_q <= '0;
            pre_q <= PRE_CLEARED;
            wdt_q <= WDT_CLEARED;
            faddr_q <= 7'h00;
            for (int i = 0; i < FILE_DEPTH; i++) begin
                file_q[i] <= 8'h00;
            end
            run_q <= 1'b1;
            sleep_q <= 1'b0;
            stable_q <= 1'b0;
            hc_q <= '0;
        end else begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            w_q <= w_d;
            flags_q <= flags_d;
            pwr_q <= pwr_d;
            st_q <= st_d;
            ost_q <= ost_d;
            pre_q <= pre_d;
            wdt_q <= wdt_d;
            faddr_q <= faddr_d;
            file_q <= file_d;
            run_q <= run_d;
            sleep_q <= sleep_d;
            stable_q <= stable_d;
            hc_q <= hc_d;
        end
    end

    assign readdata = rdata_q;
    assign waitrequest = wait_q;
    assign osc_run = run_q;
    assign sleeping = sleep_q;
    assign osc_stable = stable_q;

    logic [7:0] chk_w;
    assign chk_w = w_q;

    property p_lit_result;
        @(posedge ref_clk) disable iff (srst)
        cmd_acc && cmd_op == OP_LIT |=> chk_w == 8'($past(cmd_lit) - $past(chk_w));
    endproperty
    a_lit_result: assert property (p_lit_result) else $error("literal difference wrong");

    property p_lit_flags;
        @(posedge ref_clk) disable iff (srst)
        cmd_acc && cmd_op == OP_LIT |=>
            flags_q.carry == ($past(chk_w) <= $past(cmd_lit)) &&
            flags_q.half_carry_flag == ($past(chk_w[3:0]) <= $past(cmd_lit[3:0]));
    endproperty
    a_lit_flags: assert property (p_lit_flags) else $error("literal carry wrong");

    property p_file_carry;
        @(posedge ref_clk) disable iff (srst)
        cmd_acc && cmd_op == OP_FILE |=>
            flags_q.carry == ($past(chk_w) <= $past(cmd_fval)) &&
            flags_q.half_carry_flag == ($past(chk_w[3:0]) <= $past(cmd_fval[3:0]));
    endproperty
    a_file_carry: assert property (p_file_carry) else $error("file carry wrong");

    property p_dest_file;
        @(posedge ref_clk) disable iff (srst)
        cmd_acc && cmd_op != OP_LIT && cmd_op != OP_SLEEP && cmd_dest |=> $stable(chk_w);
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("W changed for file dest");

    property p_borrow;
        @(posedge ref_clk) disable iff (srst)
        cmd_acc && cmd_op == OP_BORROW && !cmd_dest |=>
            chk_w == 8'($past(cmd_fval) - $past(chk_w) - 8'(!$past(flags_q.carry)));
    endproperty
    a_borrow: assert property (p_borrow) else $error("borrow difference wrong");

    property p_borrow_carry;
        @(posedge ref_clk) disable iff (srst)
        cmd_acc && cmd_op == OP_BORROW |=> flags_q.carry ==
            ({1'b0, $past(cmd_fval)} >= {1'b0, $past(chk_w)} + 9'(!$past(flags_q.carry)));
    endproperty
    a_borrow_carry: assert property (p_borrow_carry) else $error("borrow carry wrong");

    property p_zero;
        @(posedge ref_clk) disable iff (srst)
        cmd_acc && cmd_op != OP_SLEEP && (cmd_op == OP_LIT || !cmd_dest) |=>
            flags_q.zero == (chk_w == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_sleep_state;
        @(posedge ref_clk) disable iff (srst)
        cmd_acc && cmd_op == OP_SLEEP |=> wdt_q == WDT_CLEARED && pre_q == PRE_CLEARED
            && pwr_q.timeout_flag && !pwr_q.power_down_flag;
    endproperty
    a_sleep_state: assert property (p_sleep_state) else $error("sleep flags wrong");

    property p_sleep_halt;
        @(posedge ref_clk) disable iff (srst)
        cmd_acc && cmd_op == OP_SLEEP |=> (!osc_run && sleeping && !osc_stable) [*3];
    endproperty
    a_sleep_halt: assert property (p_sleep_halt) else $error("oscillator not stopped");

    property p_ost;
        @(posedge ref_clk) disable iff (srst)
        $rose(osc_stable) |-> hc_q == OST_W'(OST_CYCLES);
    endproperty
    a_ost: assert property (p_ost) else $error("start-up period wrong");

    c_borrow_chain: cover property (@(posedge ref_clk) disable iff (srst)
        cmd_acc && cmd_op == OP_BORROW && !flags_q.carry);
    c_sleep: cover property (@(posedge ref_clk) disable iff (srst)
        cmd_acc && cmd_op == OP_SLEEP);
    c_wake_stable: cover property (@(posedge ref_clk) disable iff (srst)
        wake_acc ##1 (!osc_stable) [*8]);
endmodule

/* hdl/sub_exec_pkg.sv */
// Constants, register map and types for the subtract and sleep execution unit
package sub_exec_pkg;
    localparam int ADDR_W = 5;
    localparam logic [4:0] ADDR_CMD = 5'h00;
    localparam logic [4:0] ADDR_WREG = 5'h04;
    localparam logic [4:0] ADDR_STATUS = 5'h08;
    localparam logic [4:0] ADDR_FADDR = 5'h0C;
    localparam logic [4:0] ADDR_FDATA = 5'h10;
    localparam logic [4:0] ADDR_WDT = 5'h14;
    localparam logic [4:0] ADDR_WAKE = 5'h18;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_DEST_BIT = 2;
    localparam int CMD_FA_LSB = 8;
    localparam int CMD_LIT_LSB = 16;
    localparam int ST_C_BIT = 0;
    localparam int ST_DC_BIT = 1;
    localparam int ST_Z_BIT = 2;
    localparam int ST_PD_BIT = 3;
    localparam int ST_TO_BIT = 4;
    localparam int ST_SLEEP_BIT = 5;
    localparam int ST_STABLE_BIT = 6;
    localparam int WDT_PRE_LSB = 8;
    localparam logic [7:0] WDT_CLEARED = 8'h00;
    localparam logic [7:0] PRE_CLEARED = 8'h00;
    localparam logic [7:0] W_RESET = 8'h00;
    // Start-up period in oscillator periods; one ref_clk edge per period
    localparam int OST_PERIOD_TOSC = 1024;
    localparam int TOSC_PER_CLK = 1;
    localparam int OST_CYCLES = OST_PERIOD_TOSC / TOSC_PER_CLK;
    localparam int OST_W = 11;
    typedef enum logic [1:0] {OP_LIT, OP_FILE, OP_BORROW, OP_SLEEP} op_e;
    typedef enum logic [1:0] {ST_OST, ST_RUN, ST_SLEEP} pwr_state_e;
    typedef struct packed {
        logic zero;
        logic half_carry_flag;
        logic carry;
    } alu_flags_s;
    typedef struct packed {
        logic timeout_flag;
        logic power_down_flag;
    } pwr_flags_s;
    localparam alu_flags_s FLAGS_RESET = 3'h0;
    localparam pwr_flags_s PWR_RESET = 2'h3;
endpackage

/* verif/tb_top.sv */
// Self-checking testbench for the subtract and sleep execution unit
`timescale 1ns/1ps
module tb_top import sub_exec_pkg::*; ;
    logic ref_clk;
    logic srst;
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic waitrequest;
    logic osc_run;
    logic sleeping;
    logic osc_stable;
    int miscompares;
    int checks;
    int cyc;
    logic [31:0] rd;
    logic [7:0] pwr_base;

    subtract_and_sleep_exec_unit dut (.ref_clk(ref_clk), .srst(srst), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .osc_run(osc_run), .sleeping(sleeping),
        .osc_stable(osc_stable));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Edges since reset release
    always @(posedge ref_clk) cyc <= srst ? 0 : cyc + 1;

    task automatic stop_test;
        if (miscompares == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // One Avalon access; returns one edge after release
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        address <= a;
        write <= wr;
        read <= ~wr;
        writedata <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        if (n >= 50) begin
            miscompares++;
            $display("mismatch %0t bus answer timed out", $time);
            stop_test();
        end
        read <= 1'b0;
        write <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wait_stable;
        int n;
        n = 0;
        while (osc_stable !== 1'b1 && n < 2000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 2000) begin
            miscompares++;
            $display("mismatch %0t start-up timer never finished", $time);
            stop_test();
        end
    endtask

    // Expected {z, dc, c, result} of a - b - bin
    function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b,
        input logic bin);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} - {1'b0, b} - {8'h00, bin};
        low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
        return {full[7:0] == 8'h00, ~low[4], ~full[8], full[7:0]};
    endfunction

    task automatic run_op(input logic [1:0] op, input logic dest, input logic [6:0] fa,
        input logic [7:0] lit, input logic [7:0] w, input logic [7:0] fv, input logic cin);
        logic [10:0] e;
        logic to_file;
        e = sub8((op == 2'h0) ? lit : fv, w, (op == 2'h2) ? ~cin : 1'b0);
        to_file = (op != 2'h0) && dest;
        bus(1'b1, ADDR_WREG, {24'h0, w}, rd);
        bus(1'b1, ADDR_FADDR, {25'h0, fa}, rd);
        bus(1'b1, ADDR_FDATA, {24'h0, fv}, rd);
        bus(1'b1, ADDR_STATUS, {31'h0, cin}, rd);
        bus(1'b1, ADDR_CMD, {8'h00, lit, 1'b0, fa, 5'h00, dest, op}, rd);
        bus(1'b0, ADDR_WREG, 32'h0, rd);
        chk(rd, {24'h0, to_file ? w : e[7:0]}, "w result");
        bus(1'b0, ADDR_FDATA, 32'h0, rd);
        chk(rd, {24'h0, to_file ? e[7:0] : fv}, "file result");
        bus(1'b0, ADDR_STATUS, 32'h0, rd);
        chk(rd, {24'h0, pwr_base | {5'h00, e[10:8]}}, "flags");
    endtask

    task automatic sleep_and_wake;
        int t0;
        bus(1'b1, ADDR_CMD, 32'h0000_0003, rd);
        chk({29'h0, sleeping, osc_run, osc_stable}, 32'h4, "sleep pins");
        bus(1'b0, ADDR_STATUS, 32'h0, rd);
        chk(rd & 32'h78, 32'h30, "sleep status");
        bus(1'b0, ADDR_WDT, 32'h0, rd);
        chk(rd, {16'h0, PRE_CLEARED, WDT_CLEARED}, "watchdog cleared");
        bus(1'b1, ADDR_WREG, 32'h0000_0033, rd);
        bus(1'b1, ADDR_CMD, 32'h0011_0000, rd);
        bus(1'b0, ADDR_WREG, 32'h0, rd);
        chk(rd, 32'h33, "command while asleep");
        bus(1'b1, ADDR_WAKE, 32'h1, rd);
        chk({31'h0, osc_run}, 32'h1, "oscillator restarted");
        // Edge count at the wake edge; start-up runs from there
        t0 = cyc;
        wait_stable();
        chk({31'h0, (cyc - t0) == OST_CYCLES}, 32'h1, "wake start-up length");
        chk({31'h0, sleeping}, 32'h0, "awake");
    endtask

    initial begin
        srst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = '0;
        writedata = 32'h0;
        miscompares = 0;
        checks = 0;
        pwr_base = 8'h58;
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        bus(1'b0, ADDR_STATUS, 32'h0, rd);
        chk(rd, 32'h18, "reset status");
        bus(1'b1, ADDR_WREG, 32'h0000_0005, rd);
        bus(1'b1, ADDR_CMD, 32'h0003_0000, rd);
        bus(1'b0, ADDR_WREG, 32'h0, rd);
        chk(rd, 32'h05, "command before stable");
        wait_stable();
        chk({31'h0, cyc == OST_CYCLES}, 32'h1, "start-up length");
        bus(1'b0, 5'h1C, 32'h0, rd);
        chk(rd, 32'h0, "unmapped read");
        bus(1'b0, ADDR_CMD, 32'h0, rd);
        chk(rd, 32'h0, "command read");
        run_op(2'h0, 1'b1, 7'h00, 8'h03, 8'h05, 8'h00, 1'b0);
        run_op(2'h0, 1'b0, 7'h00, 8'hAA, 8'hAA, 8'h00, 1'b1);
        run_op(2'h0, 1'b0, 7'h00, 8'hFF, 8'h0F, 8'h00, 1'b0);
        run_op(2'h1, 1'b0, 7'h7F, 8'h00, 8'h01, 8'h10, 1'b0);
        run_op(2'h1, 1'b1, 7'h00, 8'h00, 8'h20, 8'h10, 1'b1);
        run_op(2'h2, 1'b0, 7'h05, 8'h00, 8'h10, 8'h10, 1'b0);
        run_op(2'h2, 1'b1, 7'h7F, 8'h00, 8'h10, 8'h10, 1'b1);
        run_op(2'h2, 1'b1, 7'h22, 8'h00, 8'h01, 8'h80, 1'b0);
        sleep_and_wake();
        pwr_base = 8'h50;
        run_op(2'h1, 1'b0, 7'h01, 8'h00, 8'h09, 8'h08, 1'b0);
        stop_test();
    end
endmodule
